// ==== hw/soc_out_route.sv ====
`timescale 1ns/100ps
module soc_out_route #(
  parameter bit FRAME_CAPABLE = 1'b0
) (
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  input  wire logic [soc_pkg::SEL_W-1:0] src_sel,
  input  wire logic [1:0]               frame_sel,
  input  wire logic                     gen_src,
  input  wire logic                     aux_src,
  input  wire logic                     frame_comp,
  input  wire logic                     frame_8k,
  input  wire logic                     frame_2k,
  output logic                          out_clk,
  output logic                          out_oe
);
  import soc_pkg::*;

  logic next_out;
  logic next_oe;

  // Source choice per select code; undriven codes tri-state
  always_comb begin
    next_out = 1'b0;
    next_oe  = 1'b0;
    case (src_sel)
      SRC_GEN: begin
        next_out = gen_src;
        next_oe  = 1'b1;
      end
      SRC_FRAME: begin
        if (FRAME_CAPABLE) begin
          next_oe = 1'b1;
          case (frame_sel)
            FMUX_COMPOSITE: next_out = frame_comp;
            FMUX_PULSE_8K:  next_out = frame_8k;
            FMUX_PULSE_2K:  next_out = frame_2k;
            default:        next_out = 1'b0;
          endcase
        end
      end
      SRC_AUX: begin
        if (FRAME_CAPABLE) begin
          next_out = aux_src;
          next_oe  = 1'b1;
        end
      end
      default: begin
        next_out = 1'b0;
        next_oe  = 1'b0;
      end
    endcase
  end

  // Output pair leaves straight from flip-flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_clk <= 1'b0;
      out_oe  <= 1'b0;
    end else begin
      out_clk <= next_out;
      out_oe  <= next_oe;
    end
  end

endmodule : soc_out_route

// ==== hw/soc_pkg.sv ====
package soc_pkg;

  // Host bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register byte addresses
  localparam logic [7:0] OFS_SYNTH_INDEX     = 8'h4a;
  localparam logic [7:0] OFS_FREQ_LOW        = 8'h4b;
  localparam logic [7:0] OFS_FREQ_MID        = 8'h4c;
  localparam logic [7:0] OFS_FREQ_HIGH       = 8'h4d;
  localparam logic [7:0] OFS_SKEW_LOW        = 8'h4e;
  localparam logic [7:0] OFS_SKEW_HIGH       = 8'h4f;
  localparam logic [7:0] OFS_LEVEL_SELECT    = 8'h50;
  localparam logic [7:0] OFS_OUT_ONE_SOURCE  = 8'h51;
  localparam logic [7:0] OFS_OUT_TWO_SOURCE  = 8'h52;
  localparam logic [7:0] OFS_OUT_THREE_SOURCE = 8'h53;

  // Synthesizer index codes
  localparam int unsigned IDX_W      = 4;
  localparam int unsigned NUM_SYNTH  = 10;
  localparam logic [3:0]  IDX_FRAME  = 4'h0;
  localparam logic [3:0]  IDX_GEN_ONE = 4'h1;
  localparam logic [3:0]  IDX_AUX    = 4'h9;
  localparam logic [3:0]  IDX_RESET  = 4'h0;

  // Word widths and byte fields
  localparam int unsigned FREQ_W        = 18;
  localparam int unsigned SKEW_W        = 12;
  localparam int unsigned FREQ_HIGH_W   = 2;
  localparam int unsigned SKEW_HIGH_W   = 4;
  localparam int unsigned SEL_W         = 2;
  localparam int unsigned LEVEL_W       = 2;
  localparam int unsigned LEVEL_ONE_BIT = 0;
  localparam int unsigned LEVEL_TWO_BIT = 1;

  // Frequency unit and supported range, in kHz
  localparam int unsigned FREQ_UNIT_KHZ  = 1;
  localparam int unsigned FREQ_MIN_KHZ   = 1000;
  localparam int unsigned FREQ_MAX_KHZ   = 156250;
  localparam int unsigned FRAME_FAST_KHZ = 8;
  localparam int unsigned FRAME_SLOW_KHZ = 2;

  // Skew step is 3.125/128 ns; range -50 ns to 49.976 ns
  localparam real SKEW_STEP_NS = 3.125 / 128.0;

  // Reset frequency words per index; the frame entry is fixed, not a word
  typedef logic [17:0] soc_freq_t;
  localparam soc_freq_t FREQ_RST [0:9] = '{
    18'h00000, 18'h25f80, 18'h1e848, 18'h04bf0, 18'h097e0,
    18'h00800, 18'h061a8, 18'h0c350, 18'h00608, 18'h00800
  };
  localparam logic [11:0] SKEW_RST  = 12'h000;
  localparam logic [1:0]  LEVEL_RST = 2'h0;
  localparam logic [1:0]  SEL_RST   = 2'h0;

  // Output source select codes
  localparam logic [1:0] SRC_TRI   = 2'h0;
  localparam logic [1:0] SRC_GEN   = 2'h1;
  localparam logic [1:0] SRC_FRAME = 2'h2;
  localparam logic [1:0] SRC_AUX   = 2'h3;

  // Frame multiplexer field codes; output three owns bits 1..0
  localparam logic [1:0]  FMUX_COMPOSITE = 2'h0;
  localparam logic [1:0]  FMUX_PULSE_8K  = 2'h1;
  localparam logic [1:0]  FMUX_PULSE_2K  = 2'h2;
  localparam logic [1:0]  FMUX_GROUND    = 2'h3;
  localparam int unsigned FMUX_FIELD_W   = 2;
  localparam int unsigned FMUX_OUT3_LSB  = 0;

  // Source pin vector positions
  localparam int unsigned SRC_NUM      = 7;
  localparam int unsigned PIN_GEN_ONE  = 0;
  localparam int unsigned PIN_GEN_TWO  = 1;
  localparam int unsigned PIN_GEN_THR  = 2;
  localparam int unsigned PIN_AUX      = 3;
  localparam int unsigned PIN_COMP     = 4;
  localparam int unsigned PIN_F8K      = 5;
  localparam int unsigned PIN_F2K      = 6;

endpackage : soc_pkg

// ==== hw/soc_synth_bank.sv ====
`timescale 1ns/100ps
module soc_synth_bank (
  input  wire logic                                       core_clk,
  input  wire logic                                       nrst,
  input  wire logic [soc_pkg::IDX_W-1:0]                  sel,
  input  wire logic                                       freq_we,
  input  wire logic [soc_pkg::FREQ_W-1:0]                 freq_wdata,
  input  wire logic                                       skew_we,
  input  wire logic [soc_pkg::SKEW_W-1:0]                 skew_wdata,
  output logic      [soc_pkg::FREQ_W-1:0]                 rd_freq,
  output logic      [soc_pkg::SKEW_W-1:0]                 rd_skew,
  output logic      [soc_pkg::NUM_SYNTH-1:0][soc_pkg::FREQ_W-1:0] all_freq,
  output logic      [soc_pkg::NUM_SYNTH-1:0][soc_pkg::SKEW_W-1:0] all_skew
);
  import soc_pkg::*;

  logic [FREQ_W-1:0] freq      [0:NUM_SYNTH-1];
  logic [FREQ_W-1:0] next_freq [0:NUM_SYNTH-1];
  logic [SKEW_W-1:0] skew      [0:NUM_SYNTH-1];
  logic [SKEW_W-1:0] next_skew [0:NUM_SYNTH-1];
  logic              sel_ok;

  // Index codes 10 to 15 select no entry
  assign sel_ok = (sel < IDX_W'(NUM_SYNTH));

  // Whole words replace the indexed entry in one edge
  always_comb begin
    next_freq = freq;
    next_skew = skew;
    if (freq_we && sel_ok) begin
      next_freq[sel] = freq_wdata;
    end
    if (skew_we && sel_ok) begin
      next_skew[sel] = skew_wdata;
    end
  end

  // Per synthesizer defaults at reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_SYNTH; i++) begin
        freq[i] <= FREQ_RST[i];
        skew[i] <= SKEW_RST;
      end
    end else begin
      freq <= next_freq;
      skew <= next_skew;
    end
  end

  // Indexed read-back and flat view for the synthesizer core
  always_comb begin
    rd_freq = sel_ok ? freq[sel] : '0;
    rd_skew = sel_ok ? skew[sel] : '0;
    for (int i = 0; i < NUM_SYNTH; i++) begin
      all_freq[i] = freq[i];
      all_skew[i] = skew[i];
    end
  end

endmodule : soc_synth_bank

// ==== hw/soc_synth_output_config.sv ====
// Overview of operation
// - Four-bit index selects frame, general or auxiliary
// - Outputs take matching general or shared synthesizers
// - Eighteen-bit frequency word over three bytes
// - Frequency word counts kilohertz, one to 156.25 MHz
// - Frame synthesizer frequency writes are ignored
// - Each synthesizer resets to its own frequency
// - Twelve-bit skew word over two bytes
// - Skew is two's complement in fine steps
// - All skew words reset to zero
// - Frame synthesizer skew stays programmable
// - Level bits pick LVPECL or LVDS
// - Output one routes general one on code 1
// - Output two routes general two on code 1
// - Output three: tri, general, frame, auxiliary
// - Frame field picks composite, 8k or 2k pulse
// - Output three alone owns a two-bit frame field
`timescale 1ns/100ps
module soc_synth_output_config (
  input  wire logic                                      core_clk,
  input  wire logic                                      nrst,
  input  wire logic [soc_pkg::ADDR_W-1:0]                reg_addr,
  input  wire logic [soc_pkg::DATA_W-1:0]                reg_wdata,
  input  wire logic                                      reg_wr,
  input  wire logic                                      reg_rd,
  output logic      [soc_pkg::DATA_W-1:0]                reg_rdata,
  input  wire logic [1:0]                                frame_mux_out3,
  input  wire logic                                      general_synth_one,
  input  wire logic                                      general_synth_two,
  input  wire logic                                      general_synth_three,
  input  wire logic                                      aux_path_synth,
  input  wire logic                                      frame_composite,
  input  wire logic                                      frame_pulse_8khz,
  input  wire logic                                      frame_pulse_2khz,
  output logic                                           out_clock_one,
  output logic                                           out_clock_one_oe,
  output logic                                           out_clock_two,
  output logic                                           out_clock_two_oe,
  output logic                                           out_clock_three,
  output logic                                           out_clock_three_oe,
  output logic                                           out_one_lvds,
  output logic                                           out_two_lvds,
  output logic [soc_pkg::NUM_SYNTH-1:0][soc_pkg::FREQ_W-1:0] synth_freq_word,
  output logic [soc_pkg::NUM_SYNTH-1:0][soc_pkg::SKEW_W-1:0] synth_skew_word
);
  import soc_pkg::*;

  // Register state
  logic [IDX_W-1:0]   idx;
  logic [IDX_W-1:0]   next_idx;
  logic [7:0]         freq_stage_low;
  logic [7:0]         next_freq_stage_low;
  logic [7:0]         freq_stage_mid;
  logic [7:0]         next_freq_stage_mid;
  logic [7:0]         skew_stage_low;
  logic [7:0]         next_skew_stage_low;
  logic [LEVEL_W-1:0] level;
  logic [LEVEL_W-1:0] next_level;
  logic [SEL_W-1:0]   sel_one;
  logic [SEL_W-1:0]   next_sel_one;
  logic [SEL_W-1:0]   sel_two;
  logic [SEL_W-1:0]   next_sel_two;
  logic [SEL_W-1:0]   sel_three;
  logic [SEL_W-1:0]   next_sel_three;
  logic [DATA_W-1:0]  rdata;
  logic [DATA_W-1:0]  next_rdata;

  // Bank handshake
  logic               freq_we;
  logic [FREQ_W-1:0]  freq_wdata;
  logic               skew_we;
  logic [SKEW_W-1:0]  skew_wdata;
  logic [FREQ_W-1:0]  bank_rd_freq;
  logic [SKEW_W-1:0]  bank_rd_skew;

  // Source pin synchronisers
  logic [SRC_NUM-1:0] src_pins;
  logic [SRC_NUM-1:0] src_meta;
  logic [SRC_NUM-1:0] src_sync;

  assign src_pins[PIN_GEN_ONE] = general_synth_one;
  assign src_pins[PIN_GEN_TWO] = general_synth_two;
  assign src_pins[PIN_GEN_THR] = general_synth_three;
  assign src_pins[PIN_AUX]     = aux_path_synth;
  assign src_pins[PIN_COMP]    = frame_composite;
  assign src_pins[PIN_F8K]     = frame_pulse_8khz;
  assign src_pins[PIN_F2K]     = frame_pulse_2khz;

  // Two-flop capture of the asynchronous synthesizer signals
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      src_meta <= '0;
      src_sync <= '0;
    end else begin
      src_meta <= src_pins;
      src_sync <= src_meta;
    end
  end

  // Word commits; a word lands only on its top byte write
  always_comb begin
    freq_wdata = {reg_wdata[FREQ_HIGH_W-1:0], freq_stage_mid, freq_stage_low};
    skew_wdata = {reg_wdata[SKEW_HIGH_W-1:0], skew_stage_low};
    // Frequency word is taken as kilohertz; range is software's duty
    freq_we = reg_wr && (reg_addr == OFS_FREQ_HIGH) && (idx != IDX_FRAME);
    // Skew for every index, frame one included
    skew_we = reg_wr && (reg_addr == OFS_SKEW_HIGH);
  end

  // Register writes
  always_comb begin
    next_idx            = idx;
    next_freq_stage_low = freq_stage_low;
    next_freq_stage_mid = freq_stage_mid;
    next_skew_stage_low = skew_stage_low;
    next_level          = level;
    next_sel_one        = sel_one;
    next_sel_two        = sel_two;
    next_sel_three      = sel_three;
    if (reg_wr) begin
      case (reg_addr)
        OFS_SYNTH_INDEX:      next_idx            = reg_wdata[IDX_W-1:0];
        OFS_FREQ_LOW:         next_freq_stage_low = reg_wdata;
        OFS_FREQ_MID:         next_freq_stage_mid = reg_wdata;
        OFS_SKEW_LOW:         next_skew_stage_low = reg_wdata;
        OFS_LEVEL_SELECT:     next_level          = reg_wdata[LEVEL_W-1:0];
        OFS_OUT_ONE_SOURCE:   next_sel_one        = reg_wdata[SEL_W-1:0];
        OFS_OUT_TWO_SOURCE:   next_sel_two        = reg_wdata[SEL_W-1:0];
        OFS_OUT_THREE_SOURCE: next_sel_three      = reg_wdata[SEL_W-1:0];
        default:              next_idx            = idx;
      endcase
    end
  end

  // Read data; words come from the bank entry at the current index
  always_comb begin
    next_rdata = rdata;
    if (reg_rd) begin
      case (reg_addr)
        OFS_SYNTH_INDEX:      next_rdata = {4'h0, idx};
        OFS_FREQ_LOW:         next_rdata = bank_rd_freq[7:0];
        OFS_FREQ_MID:         next_rdata = bank_rd_freq[15:8];
        OFS_FREQ_HIGH:        next_rdata = {6'h00, bank_rd_freq[17:16]};
        OFS_SKEW_LOW:         next_rdata = bank_rd_skew[7:0];
        OFS_SKEW_HIGH:        next_rdata = {4'h0, bank_rd_skew[11:8]};
        OFS_LEVEL_SELECT:     next_rdata = {6'h00, level};
        OFS_OUT_ONE_SOURCE:   next_rdata = {6'h00, sel_one};
        OFS_OUT_TWO_SOURCE:   next_rdata = {6'h00, sel_two};
        OFS_OUT_THREE_SOURCE: next_rdata = {6'h00, sel_three};
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idx            <= IDX_RESET;
      freq_stage_low <= 8'h00;
      freq_stage_mid <= 8'h00;
      skew_stage_low <= 8'h00;
      level          <= LEVEL_RST;
      sel_one        <= SEL_RST;
      sel_two        <= SEL_RST;
      sel_three      <= SEL_RST;
      rdata          <= 8'h00;
    end else begin
      idx            <= next_idx;
      freq_stage_low <= next_freq_stage_low;
      freq_stage_mid <= next_freq_stage_mid;
      skew_stage_low <= next_skew_stage_low;
      level          <= next_level;
      sel_one        <= next_sel_one;
      sel_two        <= next_sel_two;
      sel_three      <= next_sel_three;
      rdata          <= next_rdata;
    end
  end

  // Read data and level bits leave straight from registers
  assign reg_rdata    = rdata;
  assign out_one_lvds = level[LEVEL_ONE_BIT];
  assign out_two_lvds = level[LEVEL_TWO_BIT];

  // Per synthesizer frequency and skew store
  soc_synth_bank u_bank (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .sel        (idx),
    .freq_we    (freq_we),
    .freq_wdata (freq_wdata),
    .skew_we    (skew_we),
    .skew_wdata (skew_wdata),
    .rd_freq    (bank_rd_freq),
    .rd_skew    (bank_rd_skew),
    .all_freq   (synth_freq_word),
    .all_skew   (synth_skew_word)
  );

  // Output one: general one or tri-state
  soc_out_route #(.FRAME_CAPABLE(1'b0)) u_route_one (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .src_sel    (sel_one),
    .frame_sel  (FMUX_COMPOSITE),
    .gen_src    (src_sync[PIN_GEN_ONE]),
    .aux_src    (1'b0),
    .frame_comp (1'b0),
    .frame_8k   (1'b0),
    .frame_2k   (1'b0),
    .out_clk    (out_clock_one),
    .out_oe     (out_clock_one_oe)
  );

  // Output two: general two or tri-state
  soc_out_route #(.FRAME_CAPABLE(1'b0)) u_route_two (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .src_sel    (sel_two),
    .frame_sel  (FMUX_COMPOSITE),
    .gen_src    (src_sync[PIN_GEN_TWO]),
    .aux_src    (1'b0),
    .frame_comp (1'b0),
    .frame_8k   (1'b0),
    .frame_2k   (1'b0),
    .out_clk    (out_clock_two),
    .out_oe     (out_clock_two_oe)
  );

  // Output three: full four-way choice with frame field
  soc_out_route #(.FRAME_CAPABLE(1'b1)) u_route_three (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .src_sel    (sel_three),
    .frame_sel  (frame_mux_out3),
    .gen_src    (src_sync[PIN_GEN_THR]),
    .aux_src    (src_sync[PIN_AUX]),
    .frame_comp (src_sync[PIN_COMP]),
    .frame_8k   (src_sync[PIN_F8K]),
    .frame_2k   (src_sync[PIN_F2K]),
    .out_clk    (out_clock_three),
    .out_oe     (out_clock_three_oe)
  );

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_freq_commit;
    reg_wr && reg_addr == OFS_FREQ_HIGH && idx != IDX_FRAME && idx <= IDX_AUX;
  endsequence

  sequence s_skew_commit;
    reg_wr && reg_addr == OFS_SKEW_HIGH && idx <= IDX_AUX;
  endsequence

  a_freq_whole_word: assert property (s_freq_commit |=>
    bank_rd_freq == {$past(reg_wdata[1:0]), $past(freq_stage_mid), $past(freq_stage_low)})
    else $error("frequency word not committed whole");

  a_freq_frame_lock: assert property (
    reg_wr && reg_addr == OFS_FREQ_HIGH && idx == IDX_FRAME |=> $stable(synth_freq_word))
    else $error("frame synthesizer frequency changed");

  a_skew_whole_word: assert property (s_skew_commit |=>
    bank_rd_skew == {$past(reg_wdata[3:0]), $past(skew_stage_low)})
    else $error("skew word not committed whole");

  a_frame_skew: assert property (
    reg_wr && reg_addr == OFS_SKEW_HIGH && idx == IDX_FRAME
    |=> synth_skew_word[0] == {$past(reg_wdata[3:0]), $past(skew_stage_low)})
    else $error("frame synthesizer skew not accepted");

  a_freq_readback: assert property (
    s_freq_commit ##1 !reg_wr ##1 (reg_rd && reg_addr == OFS_FREQ_LOW)
    |=> reg_rdata == $past(freq_stage_low, 3))
    else $error("frequency low byte read mismatch");

  a_void_read: assert property (
    reg_rd && reg_addr == OFS_FREQ_HIGH && idx > IDX_AUX |=> reg_rdata == 8'h00)
    else $error("word read at unused index not zero");

  a_index_write: assert property (
    reg_wr && reg_addr == OFS_SYNTH_INDEX |=> idx == $past(reg_wdata[3:0]))
    else $error("index write not applied");

  a_index_readback: assert property (
    reg_rd && reg_addr == OFS_SYNTH_INDEX |=> reg_rdata == {4'h0, $past(idx)})
    else $error("index read mismatch");

  a_level_write: assert property (
    reg_wr && reg_addr == OFS_LEVEL_SELECT |=> {out_two_lvds, out_one_lvds} == $past(reg_wdata[1:0]))
    else $error("level select not applied");

  a_out_one_tri: assert property (
    sel_one != SRC_GEN |=> !out_clock_one_oe && !out_clock_one)
    else $error("output one driven while deselected");

  a_out_one_route: assert property (
    sel_one == SRC_GEN |=> out_clock_one_oe && out_clock_one == $past(src_sync[PIN_GEN_ONE]))
    else $error("output one not following general one");

  a_out_two_tri: assert property (
    sel_two != SRC_GEN |=> !out_clock_two_oe && !out_clock_two)
    else $error("output two driven while deselected");

  a_out_two_route: assert property (
    sel_two == SRC_GEN |=> out_clock_two_oe && out_clock_two == $past(src_sync[PIN_GEN_TWO]))
    else $error("output two not following general two");

  a_out3_tri: assert property (
    sel_three == SRC_TRI |=> !out_clock_three_oe)
    else $error("output three driven while deselected");

  a_out3_general: assert property (
    sel_three == SRC_GEN
    |=> out_clock_three_oe && out_clock_three == $past(src_sync[PIN_GEN_THR]))
    else $error("output three not following general three");

  a_out3_ground: assert property (
    sel_three == SRC_FRAME && frame_mux_out3 == FMUX_GROUND |=> out_clock_three_oe && !out_clock_three)
    else $error("output three not held low");

  a_out3_composite: assert property (
    sel_three == SRC_FRAME && frame_mux_out3 == FMUX_COMPOSITE
    |=> out_clock_three_oe && out_clock_three == $past(src_sync[PIN_COMP]))
    else $error("output three not following composite");

  a_out3_pulse8k: assert property (
    sel_three == SRC_FRAME && frame_mux_out3 == FMUX_PULSE_8K
    |=> out_clock_three == $past(src_sync[PIN_F8K]))
    else $error("output three not following 8 kHz pulse");

  a_out3_pulse2k: assert property (
    sel_three == SRC_FRAME && frame_mux_out3 == FMUX_PULSE_2K
    |=> out_clock_three_oe && out_clock_three == $past(src_sync[PIN_F2K]))
    else $error("output three not following 2 kHz pulse");

  a_out3_aux: assert property (
    sel_three == SRC_AUX |=> out_clock_three_oe && out_clock_three == $past(src_sync[PIN_AUX]))
    else $error("output three not following auxiliary");

  a_src_latency: assert property (
    sel_three == SRC_GEN && $stable(sel_three) |=> out_clock_three == $past(general_synth_three, 3))
    else $error("output three synchroniser latency wrong");

endmodule : soc_synth_output_config

// ==== tb/soc_synth_output_config_tb.sv ====
`timescale 1ns/100ps
module soc_synth_output_config_tb;
  import soc_pkg::*;
  logic                                  core_clk;
  logic                                  nrst;
  logic [7:0]                            reg_addr;
  logic [7:0]                            reg_wdata;
  logic                                  reg_wr;
  logic                                  reg_rd;
  logic [7:0]                            reg_rdata;
  logic [1:0]                            frame_mux_out3;
  logic [6:0]                            src;
  logic [2:0]                            oclk;
  logic [2:0]                            ooe;
  logic                                  out_one_lvds;
  logic                                  out_two_lvds;
  logic [NUM_SYNTH-1:0][FREQ_W-1:0]      synth_freq_word;
  logic [NUM_SYNTH-1:0][SKEW_W-1:0]      synth_skew_word;
  int                                    fail_count = 0;
  int                                    n_tests = 0;
  logic [7:0]                            q;
  logic [1:0]                            e;
  // Reset frequencies in kHz per index
  localparam int EXP_FREQ [0:9] = '{0, 155520, 125000, 19440, 38880, 2048, 25000, 50000, 1544,
                                    2048};
  // Rows of address, write data, expected read back
  localparam logic [23:0] ROWS [0:5] = '{24'h4a0505, 24'h500303, 24'h510101, 24'h520202,
                                         24'h530303, 24'h60ff00};

  soc_synth_output_config uut (
    .core_clk            (core_clk),
    .nrst                (nrst),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .frame_mux_out3      (frame_mux_out3),
    .general_synth_one   (src[0]),
    .general_synth_two   (src[1]),
    .general_synth_three (src[2]),
    .aux_path_synth      (src[3]),
    .frame_composite     (src[4]),
    .frame_pulse_8khz    (src[5]),
    .frame_pulse_2khz    (src[6]),
    .out_clock_one       (oclk[0]),
    .out_clock_one_oe    (ooe[0]),
    .out_clock_two       (oclk[1]),
    .out_clock_two_oe    (ooe[1]),
    .out_clock_three     (oclk[2]),
    .out_clock_three_oe  (ooe[2]),
    .out_one_lvds        (out_one_lvds),
    .out_two_lvds        (out_two_lvds),
    .synth_freq_word     (synth_freq_word),
    .synth_skew_word     (synth_skew_word)
  );

  // Clock at 200 MHz
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  // One-cycle read strobe, data taken once registered
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    $display("watchdog expired");
    results();
  end

  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    frame_mux_out3 = 2'h0;
    src = 7'h00;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    // Reset state of words, index, levels and enables
    for (int i = 0; i < 10; i++) begin
      chk("freq_rst", synth_freq_word[i], EXP_FREQ[i]);
      chk("skew_rst", synth_skew_word[i], 32'h0);
    end
    rd(8'h4a, q);
    chk("index_rst", q, 32'h0);
    chk("oe_rst", {ooe, out_two_lvds, out_one_lvds}, 32'h0);
    $display("test reset done");
    // Plain register write and read back
    foreach (ROWS[i]) begin
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16], q);
      chk("readback", q, ROWS[i][7:0]);
    end
    $display("test rows done");
    // Each level bit drives its own output
    wr(8'h50, 8'h02);
    repeat (2) @(negedge core_clk);
    chk("lvds", {out_two_lvds, out_one_lvds}, 32'h2);
    $display("test level done");
    // Frequency word commits whole on the high byte
    wr(8'h4a, 8'h03);
    wr(8'h4b, 8'h34);
    wr(8'h4c, 8'h12);
    chk("freq_staged", synth_freq_word[3], 32'd19440);
    wr(8'h4d, 8'h02);
    chk("freq_commit", synth_freq_word[3], 32'h21234);
    rd(8'h4b, q);
    chk("freq_low", q, 32'h34);
    rd(8'h4c, q);
    chk("freq_mid", q, 32'h12);
    rd(8'h4d, q);
    chk("freq_high", q, 32'h02);
    // Frame synthesizer frequency locked, skew still accepted
    wr(8'h4a, 8'h00);
    wr(8'h4b, 8'h55);
    wr(8'h4c, 8'h55);
    wr(8'h4d, 8'h01);
    wr(8'h4e, 8'h7f);
    wr(8'h4f, 8'h0f);
    @(negedge core_clk);
    chk("frame_freq", synth_freq_word[0], 32'h0);
    chk("frame_skew", synth_skew_word[0], 32'hf7f);
    $display("test frequency done");
    // Most negative skew on the auxiliary synthesizer
    wr(8'h4a, 8'h09);
    wr(8'h4e, 8'h00);
    wr(8'h4f, 8'h08);
    rd(8'h4f, q);
    chk("skew_high", q, 32'h08);
    chk("aux_skew", synth_skew_word[9], 32'h800);
    // Unused index: word writes dropped, word reads zero
    wr(8'h4a, 8'h0c);
    wr(8'h4d, 8'h03);
    rd(8'h4d, q);
    chk("void_read", q, 32'h0);
    chk("aux_freq", synth_freq_word[9], 32'd2048);
    $display("test skew done");
    // Every select code and source polarity per output, every frame field on output three
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 4; c++) begin
        for (int f = 0; f < ((k == 2) ? 4 : 1); f++) begin
          for (int v = 0; v < 2; v++) begin
            @(negedge core_clk);
            src = v ? 7'h2a : 7'h55;
            frame_mux_out3 = f[1:0];
            wr(8'h51 + k[7:0], c[7:0]);
            repeat (6) @(negedge core_clk);
            if (c == 1) e = {1'b1, src[k]};
            else if (k < 2 || c == 0) e = 2'b00;
            else if (c == 3) e = {1'b1, src[3]};
            else if (f == 3) e = 2'b10;
            else e = {1'b1, src[4 + f]};
            chk("route_oe", ooe[k], e[1]);
            if (e[1]) chk("route_out", oclk[k], e[0]);
          end
        end
      end
    end
    $display("test routing done");
    // Reset in mid-run restores defaults
    @(negedge core_clk);
    nrst = 1'b0;
    @(negedge core_clk);
    nrst = 1'b1;
    chk("freq_rerst", synth_freq_word[3], 32'd19440);
    chk("skew_rerst", synth_skew_word[0], 32'h0);
    rd(8'h4a, q);
    chk("index_rerst", q, 32'h0);
    $display("test second reset done");
    results();
  end
endmodule : soc_synth_output_config_tb
